/* File: core/ern_notify.sv */
// Early receive and early transmit notification logic with paged registers
//
// Function
// R1: Header interrupt past 64 bytes of matched frame
// R2: Early interrupt sets flags only, result stays clear
// R3: Early interrupt on each filled ring page
// R4: Byte count readable as low and high byte
// R5: Good frame sets both received flags
// R6: Faulty frame reports fault bits in both registers; CRC and ring overrun faults set no receive result bit
// R7: Diagnostic bit 3 selects early receive mode
// R8: Software must gather fragments over several interrupts
// R9: Interrupt flags: received bit 0, fault bit 2
// R10: Result bit 0 only on final reception
// R11: Ring write page readable on page one
// R12: Write page holds mid-frame, advances on completion
// R13: Driver rounds byte count down to even
// R14: Driver computes read start, wraps at end page
// R15: Driver reads header first, then rest rounded up
// R16: Early transmit underrun sets status and fault flags
// R17: Interrupt when transmit read passes host write
// R18: Normal mode needs whole packet before transmit
// R19: Detect transmit racing the host fill
// R20: Ring of 256-byte pages between bounds
// R21: Completion writes status, next page, count header
// R22: Interrupt line follows enabled, set flags
// R23: Byte count cleared per frame, one per byte
module ern_notify
   import ern_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [ERN_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Receive path events
   input wire logic rx_frame_start_i,
   input wire logic rx_addr_match_i,
   input wire logic rx_byte_valid_i,
   input wire logic rx_frame_end_i,
   input wire logic rx_crc_ok_i,
   input wire logic rx_alignment_fault_i,
   input wire logic rx_extended_fault_i,
   input wire logic rx_missed_frame_i,
   input wire logic rx_ring_overrun_i,
   // Transmit path positions
   input wire logic tx_start_i,
   input wire logic tx_active_i,
   input wire logic [15:0] tx_local_read_pos_i,
   input wire logic [15:0] tx_host_write_pos_i,
   // Frame header write to the ring
   output logic hdr_write_o,
   output logic [7:0] hdr_page_o,
   output logic [7:0] hdr_status_o,
   output logic [7:0] hdr_next_page_o,
   output logic [15:0] hdr_byte_count_o,
   // Host interrupt and transmit hold
   output logic irq_o,
   output logic tx_local_hold_o
);
   import ern_pkg::*;

   // ***************************************************************
   // Register state
   // ***************************************************************
   logic [1:0] page_sel;            // Register page in view
   logic [7:0] interrupt_flags;     // Sticky event flags
   logic [7:0] interrupt_mask;      // Enables for the interrupt line
   logic [7:0] receive_result;      // Result of the last frame
   logic [7:0] tx_status;           // Transmit status, underrun bit
   logic [7:0] ring_write_page;     // Next receive page
   logic [7:0] ring_first_page;     // Lower ring bound
   logic [7:0] ring_end_page;       // Upper ring bound, exclusive
   logic [7:0] ring_read_page;      // Next page software removes
   logic [7:0] diag_reg;            // Diagnostic register
   logic [7:0] config_b;            // Configuration B register

   // ***************************************************************
   // Receive and transmit tracking
   // ***************************************************************
   logic [15:0] rx_byte_count;      // Running count of current frame
   logic rx_page_full;              // Pulse when a ring page fills
   logic [7:0] rx_next_page;        // Page after the frame's last page
   logic rx_in_frame;               // Frame is being received
   logic rx_matched;                // Frame passed the address filter
   logic rx_header_done;            // Header interrupt already given
   logic early_rx_enable;           // Early receive mode selected
   logic early_tx_enable;           // Early transmit detection selected
   logic rx_good_end;               // Completion without fault
   logic rx_bad_end;                // Completion with any fault
   logic early_event;               // Header or page early interrupt
   logic tx_underrun;               // Transmit read passed host write

   // ***************************************************************
   // Event decode
   // ***************************************************************
   assign early_rx_enable = diag_reg[ERN_BIT_EARLY_RX_ENABLE];          // [R7]
   assign early_tx_enable = config_b[ERN_BIT_EARLY_TX_ENABLE];

   // A completed frame counts only if it was addressed to this node
   assign rx_good_end = rx_frame_end_i && rx_matched && rx_crc_ok_i
      && !rx_alignment_fault_i && !rx_extended_fault_i
      && !rx_missed_frame_i && !rx_ring_overrun_i;
   assign rx_bad_end = rx_frame_end_i && rx_matched && !rx_good_end;

   // Early events: header past 64 bytes once, then every filled page
   assign early_event = early_rx_enable && rx_in_frame && rx_matched
      && ((!rx_header_done && (rx_byte_count > ERN_EARLY_HDR_BYTES))    // [R1]
      || rx_page_full);                                                 // [R3]

   // Local read overtaking the host fill would send stale bytes
   assign tx_underrun = early_tx_enable && tx_active_i
      && (tx_host_write_pos_i < tx_local_read_pos_i);                   // [R19] [R17]

   // ***************************************************************
   // Ring position tracker
   // ***************************************************************
   ern_ring_track u_ring_track (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .frame_start_i(rx_frame_start_i),
      .byte_valid_i(rx_byte_valid_i),
      .frame_end_i(rx_frame_end_i),
      .ring_first_page_i(ring_first_page),
      .ring_end_page_i(ring_end_page),
      .ring_write_page_i(ring_write_page),
      .byte_count_o(rx_byte_count),
      .page_full_o(rx_page_full),
      .next_frame_page_o(rx_next_page)
   );

   // ***************************************************************
   // Frame progress
   // ***************************************************************

   // Frame window, filter result and header interrupt memory
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rx_in_frame <= 1'b0;
         rx_matched <= 1'b0;
         rx_header_done <= 1'b0;
      end else if (rx_frame_start_i) begin
         rx_in_frame <= 1'b1;
         rx_matched <= 1'b0;
         rx_header_done <= 1'b0;
      end else if (rx_frame_end_i) begin
         // Reception done, no more page interrupts for this frame [R3]
         rx_in_frame <= 1'b0;
      end else begin
         if (rx_addr_match_i) begin
            rx_matched <= 1'b1;
         end
         if (early_event) begin
            rx_header_done <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // Register writes
   // ***************************************************************

   // Page select and plain control registers
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         page_sel <= ERN_PAGE_0;
         interrupt_mask <= ERN_RST_BYTE;
         ring_first_page <= ERN_RST_FIRST_PAGE;
         ring_end_page <= ERN_RST_END_PAGE;
         ring_read_page <= ERN_RST_READ_PAGE;
         diag_reg <= ERN_RST_BYTE;
         config_b <= ERN_RST_BYTE;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ERN_OFS_PAGE_SEL) begin
            page_sel <= reg_wdata_i[ERN_PAGE_SEL_LSB +: 2];
         end else if (page_sel == ERN_PAGE_0 && reg_addr_i == ERN_OFS_INT_MASK) begin
            interrupt_mask <= reg_wdata_i;
         end else if (page_sel == ERN_PAGE_2) begin
            unique case (reg_addr_i)
               ERN_OFS_FIRST_PAGE: ring_first_page <= reg_wdata_i;
               ERN_OFS_END_PAGE: ring_end_page <= reg_wdata_i;
               ERN_OFS_READ_PAGE: ring_read_page <= reg_wdata_i;
               // Mode may change at any time, even mid-frame [R7]
               ERN_OFS_DIAG: diag_reg <= reg_wdata_i;
               ERN_OFS_CONFIG_B: config_b <= reg_wdata_i;
               default: ;   // Other page two offsets hold nothing
            endcase
         end
      end
   end

   // Ring write page: software writes it, good completion advances it [R11] [R12]
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ring_write_page <= ERN_RST_WRITE_PAGE;
      end else if (rx_good_end) begin
         // Hardware advance wins over a write in the same cycle
         ring_write_page <= rx_next_page;
      end else if (reg_wr_i && page_sel == ERN_PAGE_1
         && reg_addr_i == ERN_OFS_WRITE_PAGE) begin
         ring_write_page <= reg_wdata_i;
      end
   end

   // ***************************************************************
   // Status flags
   // ***************************************************************

   // Interrupt flags: write one to clear, a new event in that cycle wins
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         interrupt_flags <= ERN_RST_BYTE;
      end else begin
         if (reg_wr_i && page_sel == ERN_PAGE_0 && reg_addr_i == ERN_OFS_INT_FLAGS) begin
            interrupt_flags <= interrupt_flags & ~reg_wdata_i;
         end
         // Early and final receptions both set the received flag [R2] [R5] [R9]
         if (early_event || rx_good_end) begin
            interrupt_flags[ERN_BIT_FRAME_RECEIVED] <= 1'b1;
         end
         // Faulty completion without ring overrun reports a receive fault [R6] [R9]
         if (rx_bad_end && !rx_ring_overrun_i) begin
            interrupt_flags[ERN_BIT_RX_FAULT] <= 1'b1;
         end
         // Ring overrun reported as its own flag [R6]
         if (rx_bad_end && rx_ring_overrun_i) begin
            interrupt_flags[ERN_BIT_RING_OVERRUN] <= 1'b1;
         end
         // Transmit underrun raises the transmit fault flag [R16]
         if (tx_underrun) begin
            interrupt_flags[ERN_BIT_TX_FAULT] <= 1'b1;
         end
      end
   end

   // Receive result: cleared at each frame start, written only when a matched frame completes
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         receive_result <= ERN_RST_BYTE;
      end else if (rx_frame_start_i) begin
         // Cleared per frame so early interrupts read bit 0 low [R2] [R10]
         receive_result <= ERN_RST_BYTE;
      end else if (rx_good_end) begin
         receive_result[ERN_BIT_RESULT_RECEIVED] <= 1'b1;                // [R5] [R10]
      end else if (rx_bad_end) begin
         receive_result[ERN_BIT_ALIGNMENT_FAULT] <= rx_alignment_fault_i; // [R6]
         receive_result[ERN_BIT_EXT_RX_FAULT] <= rx_extended_fault_i;
         receive_result[ERN_BIT_MISSED_FRAME] <= rx_missed_frame_i;
      end
   end

   // Transmit status: underrun is sticky until the next transmit starts
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tx_status <= ERN_RST_BYTE;
      end else if (tx_underrun) begin
         tx_status[ERN_BIT_TX_UNDERRUN] <= 1'b1;                        // [R16]
      end else if (tx_start_i) begin
         tx_status <= ERN_RST_BYTE;
      end
   end

   // Hold the local reader when it has caught up with the host fill
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tx_local_hold_o <= 1'b0;
      end else begin
         tx_local_hold_o <= early_tx_enable && tx_active_i
            && (tx_host_write_pos_i == tx_local_read_pos_i);            // [R19]
      end
   end

   // ***************************************************************
   // Interrupt line
   // ***************************************************************

   // Line follows any set flag whose mask bit is on [R22] [R17]
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(interrupt_flags & interrupt_mask);
      end
   end

   // ***************************************************************
   // Frame header record
   // ***************************************************************

   // On good completion the four reserved bytes get status, next page, count [R21]
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         hdr_write_o <= 1'b0;
         hdr_page_o <= ERN_RST_BYTE;
         hdr_status_o <= ERN_RST_BYTE;
         hdr_next_page_o <= ERN_RST_BYTE;
         hdr_byte_count_o <= ERN_RST_COUNT;
      end else begin
         hdr_write_o <= rx_good_end;
         if (rx_good_end) begin
            hdr_page_o <= ring_write_page;
            hdr_status_o <= 8'h01;
            hdr_next_page_o <= rx_next_page;
            hdr_byte_count_o <= rx_byte_count;
         end
      end
   end

   // ***************************************************************
   // Register reads
   // ***************************************************************

   // Read data stands one cycle after the strobe, zero elsewhere
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= ERN_RST_BYTE;
      end else if (!reg_rd_i) begin
         reg_rdata_o <= ERN_RST_BYTE;
      end else if (reg_addr_i == ERN_OFS_PAGE_SEL) begin
         reg_rdata_o <= {page_sel, 6'h00};
      end else begin
         unique case (page_sel)
            ERN_PAGE_0: begin
               unique case (reg_addr_i)
                  ERN_OFS_CNT_LOW: reg_rdata_o <= rx_byte_count[7:0];     // [R4]
                  ERN_OFS_CNT_HIGH: reg_rdata_o <= rx_byte_count[15:8];   // [R4]
                  ERN_OFS_TX_STATUS: reg_rdata_o <= tx_status;
                  ERN_OFS_INT_FLAGS: reg_rdata_o <= interrupt_flags;      // [R9]
                  ERN_OFS_RX_RESULT: reg_rdata_o <= receive_result;       // [R10]
                  ERN_OFS_INT_MASK: reg_rdata_o <= interrupt_mask;
                  default: reg_rdata_o <= ERN_RST_BYTE;
               endcase
            end
            ERN_PAGE_1: begin
               if (reg_addr_i == ERN_OFS_WRITE_PAGE) begin
                  reg_rdata_o <= ring_write_page;                         // [R11]
               end else begin
                  reg_rdata_o <= ERN_RST_BYTE;
               end
            end
            ERN_PAGE_2: begin
               unique case (reg_addr_i)
                  ERN_OFS_FIRST_PAGE: reg_rdata_o <= ring_first_page;
                  ERN_OFS_END_PAGE: reg_rdata_o <= ring_end_page;
                  ERN_OFS_READ_PAGE: reg_rdata_o <= ring_read_page;
                  ERN_OFS_DIAG: reg_rdata_o <= diag_reg;
                  ERN_OFS_CONFIG_B: reg_rdata_o <= config_b;
                  default: reg_rdata_o <= ERN_RST_BYTE;
               endcase
            end
            default: reg_rdata_o <= ERN_RST_BYTE;   // Page 3 is empty
         endcase
      end
   end

endmodule // ern_notify

/* File: core/ern_ring_track.sv */
// Receive ring position tracker: running byte count, page fill and next page
module ern_ring_track
   import ern_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Frame events from the receive path
   input wire logic frame_start_i,
   input wire logic byte_valid_i,
   input wire logic frame_end_i,
   // Ring bounds and current write page
   input wire logic [7:0] ring_first_page_i,
   input wire logic [7:0] ring_end_page_i,
   input wire logic [7:0] ring_write_page_i,
   // Position results
   output logic [15:0] byte_count_o,
   output logic page_full_o,
   output logic [7:0] next_frame_page_o
);
   import ern_pkg::*;

   logic [7:0] fill_page;       // Page being filled now
   logic [7:0] fill_offset;     // Byte position inside that page
   logic [7:0] next_fill_page;  // Following page with wrap

   // Next page wraps from the end page back to the first page
   always_comb begin
      next_fill_page = fill_page + 8'h01;
      if (next_fill_page == ring_end_page_i) begin
         next_fill_page = ring_first_page_i;
      end
   end

   // Frame after this one starts on the page after the last page used [R12]
   assign next_frame_page_o = next_fill_page;

   // Fill position: first byte lands after the reserved header [R20]
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         fill_page <= ERN_RST_WRITE_PAGE;
         fill_offset <= ERN_RST_BYTE;
         page_full_o <= 1'b0;
      end else begin
         page_full_o <= 1'b0;
         if (frame_start_i) begin
            // Each frame begins at the current write page [R20]
            fill_page <= ring_write_page_i;
            fill_offset <= ERN_HEADER_BYTES;
         end else if (byte_valid_i) begin
            if (fill_offset == ERN_LAST_IN_PAGE) begin
               // Page complete, request a new one [R3]
               fill_page <= next_fill_page;
               fill_offset <= ERN_RST_BYTE;
               page_full_o <= 1'b1;
            end else begin
               fill_offset <= fill_offset + 8'h01;
            end
         end
      end
   end

   // Running byte count, zero at frame start and after completion [R23] [R12]
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         byte_count_o <= ERN_RST_COUNT;
      end else if (frame_start_i || frame_end_i) begin
         byte_count_o <= ERN_RST_COUNT;
      end else if (byte_valid_i) begin
         byte_count_o <= byte_count_o + 16'h0001;
      end
   end

endmodule // ern_ring_track

/* File: inc/ern_pkg.sv */
// Constants shared by the early receive / transmit notification block
package ern_pkg;

   // ***************************************************************
   // Bus and register offsets
   // ***************************************************************
   localparam int ERN_ADDR_W = 4;                       // Offset width
   localparam logic [3:0] ERN_OFS_PAGE_SEL = 4'h0;      // Page select, all pages
   localparam logic [3:0] ERN_OFS_CNT_LOW = 4'h1;       // Page 0, byte count low
   localparam logic [3:0] ERN_OFS_CNT_HIGH = 4'h2;      // Page 0, byte count high
   localparam logic [3:0] ERN_OFS_TX_STATUS = 4'h4;     // Page 0, transmit status
   localparam logic [3:0] ERN_OFS_INT_FLAGS = 4'h7;     // Page 0, interrupt flags
   localparam logic [3:0] ERN_OFS_RX_RESULT = 4'hC;     // Page 0, receive result
   localparam logic [3:0] ERN_OFS_INT_MASK = 4'hF;      // Page 0, interrupt mask
   localparam logic [3:0] ERN_OFS_WRITE_PAGE = 4'h7;    // Page 1, ring write page
   localparam logic [3:0] ERN_OFS_FIRST_PAGE = 4'h1;    // Page 2, ring first page
   localparam logic [3:0] ERN_OFS_END_PAGE = 4'h2;      // Page 2, ring end page
   localparam logic [3:0] ERN_OFS_READ_PAGE = 4'h3;     // Page 2, ring read page
   localparam logic [3:0] ERN_OFS_DIAG = 4'hD;          // Page 2, diagnostic
   localparam logic [3:0] ERN_OFS_CONFIG_B = 4'hE;      // Page 2, configuration B

   // ***************************************************************
   // Page numbers and page select field
   // ***************************************************************
   localparam logic [1:0] ERN_PAGE_0 = 2'h0;
   localparam logic [1:0] ERN_PAGE_1 = 2'h1;
   localparam logic [1:0] ERN_PAGE_2 = 2'h2;
   localparam int ERN_PAGE_SEL_LSB = 6;                 // Page field is bits 7:6

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int ERN_BIT_FRAME_RECEIVED = 0;           // Interrupt flags
   localparam int ERN_BIT_RX_FAULT = 2;
   localparam int ERN_BIT_TX_FAULT = 3;
   localparam int ERN_BIT_RING_OVERRUN = 4;
   localparam int ERN_BIT_RESULT_RECEIVED = 0;          // Receive result
   localparam int ERN_BIT_ALIGNMENT_FAULT = 2;
   localparam int ERN_BIT_EXT_RX_FAULT = 3;
   localparam int ERN_BIT_MISSED_FRAME = 4;
   localparam int ERN_BIT_TX_UNDERRUN = 5;              // Transmit status
   localparam int ERN_BIT_EARLY_RX_ENABLE = 3;          // Diagnostic
   localparam int ERN_BIT_EARLY_TX_ENABLE = 0;          // Configuration B

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] ERN_RST_BYTE = 8'h00;         // Flags, result, status, mask
   localparam logic [7:0] ERN_RST_FIRST_PAGE = 8'h46;
   localparam logic [7:0] ERN_RST_END_PAGE = 8'h80;
   localparam logic [7:0] ERN_RST_WRITE_PAGE = 8'h47;
   localparam logic [7:0] ERN_RST_READ_PAGE = 8'h46;
   localparam logic [15:0] ERN_RST_COUNT = 16'h0000;

   // ***************************************************************
   // Ring geometry and early thresholds
   // ***************************************************************
   localparam logic [7:0] ERN_LAST_IN_PAGE = 8'hFF;     // Last byte of a 256-byte page
   localparam logic [7:0] ERN_HEADER_BYTES = 8'h04;     // Reserved header at first page
   localparam logic [15:0] ERN_EARLY_HDR_BYTES = 16'h0040; // Header interrupt past 64

endpackage : ern_pkg

/* File: testbench/ern_host.sv */
// Host driver model: master of the block's register port
module ern_host (
   // Clock and read data
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   // Strobes, offset and write data
   output logic [3:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {addr_o, wdata_o, wr_o, rd_o} = 14'h0000;
   // One-cycle write; fragments are gathered by the caller across interrupts
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe, so sample it there
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule // ern_host

/* File: testbench/ern_notify_sva.sv */
// Port checker for the early notification block
module ern_notify_sva (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Watched ports
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic rx_frame_end_i,
   input wire logic tx_active_i,
   input wire logic [15:0] tx_local_read_pos_i,
   input wire logic [15:0] tx_host_write_pos_i,
   input wire logic hdr_write_o,
   input wire logic [7:0] hdr_status_o,
   input wire logic [7:0] hdr_next_page_o,
   input wire logic [15:0] hdr_byte_count_o,
   input wire logic irq_o,
   input wire logic tx_local_hold_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   idle_rdata_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("stray");
   rst_quiet_a: assert property ($fell(sys_rst_i) |-> !irq_o && !hdr_write_o) else $error("rst");
   hdr_pulse_a: assert property (hdr_write_o |=> !hdr_write_o) else $error("long pulse");
   hdr_cause_a: assert property (hdr_write_o |-> $past(rx_frame_end_i)) else $error("cause");
   hdr_hold_a: assert property (!hdr_write_o |-> $stable(hdr_byte_count_o) &&
      $stable(hdr_next_page_o)) else $error("header moved");
   hdr_status_a: assert property (hdr_write_o |-> hdr_status_o == 8'h01) else $error("st");
   hdr_count_a: assert property (hdr_write_o |-> hdr_byte_count_o != 16'h0000) else $error("n");
   tx_hold_a: assert property (tx_local_hold_o |-> $past(tx_active_i) &&
      $past(tx_local_read_pos_i == tx_host_write_pos_i)) else $error("hold");
   cover property (hdr_write_o);
   cover property ($rose(irq_o));
   cover property (tx_local_hold_o);
endmodule // ern_notify_sva

bind ern_notify ern_notify_sva chk_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_frame_end_i(rx_frame_end_i),
   .tx_active_i(tx_active_i), .tx_local_read_pos_i(tx_local_read_pos_i),
   .tx_host_write_pos_i(tx_host_write_pos_i), .hdr_write_o(hdr_write_o),
   .hdr_status_o(hdr_status_o), .hdr_next_page_o(hdr_next_page_o),
   .hdr_byte_count_o(hdr_byte_count_o), .irq_o(irq_o), .tx_local_hold_o(tx_local_hold_o));

/* File: testbench/tb.sv */
// Self-checking bench for the early notification block
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] ad;
   logic [7:0] wd, rdat, v, hp;
   logic wr, rd, st, mt, bv, en, ok, fa, fx, fm, fo, ts, ta, hold, irq;
   logic [15:0] rp, wp;
   int failures = 0;
   int checks_done = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   ern_host host (.clk_i(ref_clk_i), .rdata_i(rdat), .addr_o(ad), .wdata_o(wd), .wr_o(wr),
      .rd_o(rd));
   ern_notify DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(ad),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .rx_frame_start_i(st), .rx_addr_match_i(mt), .rx_byte_valid_i(bv), .rx_frame_end_i(en),
      .rx_crc_ok_i(ok), .rx_alignment_fault_i(fa), .rx_extended_fault_i(fx),
      .rx_missed_frame_i(fm), .rx_ring_overrun_i(fo), .tx_start_i(ts), .tx_active_i(ta),
      .tx_local_read_pos_i(rp), .tx_host_write_pos_i(wp), .hdr_write_o(), .hdr_page_o(hp),
      .hdr_status_o(), .hdr_next_page_o(), .hdr_byte_count_o(), .irq_o(irq),
      .tx_local_hold_o(hold));
   task automatic give_verdict();
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      host.rd(a, v);
      chk(v, exp);
   endtask
   // Burst of stored bytes, one per cycle
   task automatic bytes(input int n);
      @(posedge ref_clk_i);
      bv <= 1'b1;
      repeat (n) @(posedge ref_clk_i);
      bv <= 1'b0;
   endtask
   // Start pulse, then address match held for the frame; end never shares a byte's cycle
   task automatic edge_ev(input logic s);
      @(posedge ref_clk_i);
      {st, en} <= {s, !s};
      @(posedge ref_clk_i);
      {st, en, mt} <= {2'b00, s};
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      failures++;
      give_verdict();
   end
   initial begin
      {st, mt, bv, en, ok, fa, fx, fm, fo, ts, ta} = 11'h000;
      {rp, wp} = 32'h0000_0000;
      repeat (6) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      host.wr(4'h0, 8'h40);
      rdchk(4'h7, 8'h47);
      host.wr(4'h0, 8'h80);
      host.wr(4'hD, 8'h08);
      host.wr(4'hE, 8'h01);
      host.wr(4'h0, 8'h00);
      host.wr(4'hF, 8'h1D);
      edge_ev(1'b1);
      bytes(64);
      rdchk(4'h7, 8'h00);
      rdchk(4'h1, 8'h40);
      bytes(1);
      rdchk(4'h7, 8'h01);
      chk({7'h00, irq}, 8'h01);
      rdchk(4'hC, 8'h00);
      host.wr(4'h7, 8'hFF);
      bytes(186);
      rdchk(4'h7, 8'h00);
      bytes(1);
      rdchk(4'h7, 8'h01);
      rdchk(4'h1, 8'hFC);
      bytes(48);
      rdchk(4'h2, 8'h01);
      host.wr(4'h7, 8'hFF);
      host.wr(4'h0, 8'h40);
      rdchk(4'h7, 8'h47);
      ok <= 1'b1;
      edge_ev(1'b0);
      rdchk(4'h7, 8'h49);
      host.wr(4'h0, 8'h00);
      rdchk(4'h7, 8'h01);
      rdchk(4'hC, 8'h01);
      rdchk(4'h1, 8'h00);
      chk(hp, 8'h47);
      host.wr(4'h7, 8'hFF);
      edge_ev(1'b1);
      bytes(10);
      {ok, fa, fx, fm} <= 4'h7;
      edge_ev(1'b0);
      rdchk(4'h7, 8'h04);
      rdchk(4'hC, 8'h1C);
      fo <= 1'b1;
      edge_ev(1'b1);
      edge_ev(1'b0);
      rdchk(4'h7, 8'h14);
      host.wr(4'h7, 8'hFF);
      {ta, wp, rp} <= {1'b1, 16'h0010, 16'h0020};
      rdchk(4'h4, 8'h20);
      rdchk(4'h7, 8'h08);
      rp <= 16'h0010;
      repeat (2) @(posedge ref_clk_i);
      chk({7'h00, hold}, 8'h01);
      ts <= 1'b1;
      @(posedge ref_clk_i);
      ts <= 1'b0;
      rdchk(4'h4, 8'h00);
      give_verdict();
   end
endmodule // tb
